// File: spp_pkg.sv
// Shared constants and types for the sector and password protection block
package spp_pkg;
  localparam int SECT_W = 4;
  localparam int NUM_SECT = 16;
  localparam int NUM_SUB = 16;
  localparam int PW_W = 64;
  localparam int CFG_W = 16;
  localparam int SEAL_W = 8;
  localparam int NBITS_W = 7;

  // Protection configuration fields and values after reset
  localparam int CFG_PW_BIT = 2;
  localparam int CFG_SP_BIT = 1;
  localparam logic [15:0] CFG_RESET = 16'hFFFF;
  localparam logic [15:0] NVL_RESET = 16'hFFFF;
  localparam logic [63:0] PW_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
  localparam logic [7:0] SEAL_OPEN = 8'h01;
  localparam logic [7:0] SEAL_SHUT = 8'h00;

  // Command opcodes
  localparam logic [7:0] OP_RD_SEAL = 8'hA7;
  localparam logic [7:0] OP_WR_SEAL = 8'hA6;
  localparam logic [7:0] OP_UNLOCK_PW = 8'h29;
  localparam logic [7:0] OP_PROG_PW = 8'h28;
  localparam logic [7:0] OP_RD_PW = 8'h27;
  localparam logic [7:0] OP_RD_CFG = 8'h2D;
  localparam logic [7:0] OP_WR_CFG = 8'h2C;
  localparam logic [7:0] OP_RD_NVL = 8'hE2;
  localparam logic [7:0] OP_WR_NVL = 8'hE3;
  localparam logic [7:0] OP_ER_NVL = 8'hE4;
  localparam logic [7:0] OP_WR_VL = 8'hE5;

  // Frame lengths in bits, opcode included
  localparam logic [6:0] LEN_OP = 7'h08;
  localparam logic [6:0] LEN_B1 = 7'h10;
  localparam logic [6:0] LEN_B2 = 7'h18;
  localparam logic [6:0] LEN_PW = 7'h48;
  localparam logic [6:0] NBITS_MAX = 7'h7F;

  typedef enum logic [3:0] {
    SPP_CMD_NONE,
    SPP_CMD_WR_SEAL,
    SPP_CMD_UNLOCK,
    SPP_CMD_PROG_PW,
    SPP_CMD_WR_CFG,
    SPP_CMD_WR_NVL,
    SPP_CMD_ER_NVL,
    SPP_CMD_WR_VL
  } spp_cmd_e;

  typedef struct packed {
    logic [7:0] op;
    logic [63:0] data;
    logic [6:0] nbits;
  } spp_frame_s;

  typedef struct packed {
    logic [7:0] seal;
    logic [15:0] cfg;
    logic [15:0] nvl;
    logic [63:0] pw;
  } spp_snap_s;
endpackage

// File: spp_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module spp_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic rst_val,
  input wire logic d,
  output logic q
);
  logic meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= rst_val;
      q <= rst_val;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule
`default_nettype wire

// File: spp_link.sv
// Serial link side: frame shift-in, answer shift-out, snapshot pickup
`timescale 1ns/1ps
`default_nettype none
module spp_link (
  input wire logic link_clk,
  input wire logic link_rst,
  input wire logic link_cs_n,
  input wire logic link_si,
  output logic link_so,
  output logic link_so_oe,
  output spp_pkg::spp_frame_s frame,
  input wire spp_pkg::spp_snap_s snap,
  input wire logic snap_tog,
  output logic snap_ack
);
  import spp_pkg::*;

  logic [71:0] shift_q;
  logic [6:0] nbits_q;
  logic [63:0] out_q;
  logic loaded_q;
  logic oe_q;
  logic act_q;
  logic tog_s;
  spp_snap_s cap_q;

  function automatic logic [63:0] answer(input logic [7:0] op, input spp_snap_s s);
    logic [63:0] w;
    w = 64'h0000_0000_0000_0000;
    if (op == OP_RD_SEAL) begin
      w = {s.seal, 56'h00_0000_0000_0000};
    end else if (op == OP_RD_CFG) begin
      w = {s.cfg, 48'h0000_0000_0000};
    end else if (op == OP_RD_NVL) begin
      w = {s.nvl, 48'h0000_0000_0000};
    end else if (op == OP_RD_PW) begin
      w = s.pw;
    end
    return w;
  endfunction

  spp_sync u_tog_sync (
    .clk(link_clk),
    .rst(link_rst),
    .rst_val(1'b0),
    .d(snap_tog),
    .q(tog_s)
  );

  // Marks that the current frame has had its first bit
  always_ff @(posedge link_clk or posedge link_cs_n) begin
    if (link_cs_n) begin
      act_q <= 1'b0;
    end else begin
      act_q <= 1'b1;
    end
  end

  // Frame shift register, restarted by the first bit and held after the frame
  always_ff @(posedge link_clk) begin
    if (link_cs_n) begin
      if (link_rst) begin
        shift_q <= 72'h00_0000_0000_0000_0000;
        nbits_q <= 7'h00;
      end
    end else if (!act_q) begin
      shift_q <= {71'h00_0000_0000_0000_0000, link_si};
      nbits_q <= 7'h01;
    end else begin
      shift_q <= {shift_q[70:0], link_si};
      if (nbits_q != NBITS_MAX) begin
        nbits_q <= nbits_q + 7'h01;
      end
    end
  end

  // Answer shift-out on the falling edge after the opcode
  always_ff @(negedge link_clk or posedge link_cs_n) begin
    if (link_cs_n) begin
      out_q <= 64'h0000_0000_0000_0000;
      loaded_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (!loaded_q && nbits_q == LEN_OP) begin
      out_q <= answer(shift_q[7:0], cap_q);
      loaded_q <= 1'b1;
      oe_q <= (answer(shift_q[7:0], cap_q) != 64'h0000_0000_0000_0000) ||
              shift_q[7:0] == OP_RD_SEAL || shift_q[7:0] == OP_RD_CFG ||
              shift_q[7:0] == OP_RD_NVL || shift_q[7:0] == OP_RD_PW;
    end else if (loaded_q) begin
      out_q <= {out_q[62:0], 1'b0};
    end
  end

  // Snapshot pickup: data is held stable by the core until acknowledged
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cap_q <= '0;
      snap_ack <= 1'b0;
    end else if (tog_s != snap_ack) begin
      cap_q <= snap;
      snap_ack <= tog_s;
    end
  end

  assign link_so = out_q[63];
  assign link_so_oe = oe_q;
  assign frame.op = frame_op(shift_q, nbits_q);
  assign frame.data = shift_q[63:0];
  assign frame.nbits = nbits_q;

  function automatic logic [7:0] frame_op(input logic [71:0] s, input logic [6:0] n);
    logic [7:0] o;
    o = s[71:64];
    if (n == LEN_OP) begin
      o = s[7:0];
    end else if (n == LEN_B1) begin
      o = s[15:8];
    end else if (n == LEN_B2) begin
      o = s[23:16];
    end
    return o;
  endfunction
endmodule
`default_nettype wire

// File: spp_protect.sv
// Sector and password protection logic of the serial flash device
// Notes on behaviour
// - Sixteen-bit nonvolatile configuration; only bits 2 and 1 do anything.
// - One persistent lock bit per sector, held until erased back to 1.
// - One volatile lock bit per sector; cleared on every reset.
// - First and last sectors lock volatile per 4KB subsector.
// - Bit 2 at 0 enables password mode forever; password never read or reset.
// - Bit 1 at 0 keeps bit 2 at 1 forever.
// - Bits 2 and 1 program once each; at most one may be 0.
// - Host sets password before bit 2; afterwards password changes are refused.
// - In password mode seal goes 0 to 1 only with correct password.
// - Wrong password leaves seal alone and blocks persistent lock changes.
// - Fresh device has every sector unlocked.
// - Seal is volatile, bit 0 of 8 bits, upper bits 0, defaults 1.
// - Seal at 0 refuses program and erase of persistent lock bits.
// - Seal read command returns current seal value.
// - In password mode seal is forced closed at every reset.
// - Release command after correct password sets seal to 1.
// - Seal write command sets seal to 0.
// - Persistent lock bit 0 blocks its sector; 1 leaves it open.
// - Volatile lock bit 1 blocks sector or subsector; 0 leaves it open.
// - Persistent lock erase returns all persistent bits to 1 at once.
`timescale 1ns/1ps
`default_nettype none
module spp_protect (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic dev_rst,
  input wire logic link_clk,
  input wire logic link_cs_n,
  input wire logic link_si,
  output logic link_so,
  output logic link_so_oe,
  input wire logic [spp_pkg::SECT_W-1:0] chk_sector,
  input wire logic [spp_pkg::SECT_W-1:0] chk_sub,
  output logic chk_allow,
  output logic pw_enabled,
  output logic seal_open,
  output logic cmd_done,
  output logic cmd_refused
);
  import spp_pkg::*;

  logic link_rst;
  logic cs_s;
  logic cs_prev_q;
  logic frame_end;
  logic ack_s;
  spp_frame_s frame;
  spp_cmd_e cmd;
  logic [15:0] cfg_q;
  logic [15:0] nvl_q;
  logic [63:0] pw_q;
  logic [7:0] seal_q;
  logic pw_fail_q;
  logic [NUM_SECT-1:0] vl_q;
  logic [NUM_SUB-1:0] vl_first_q;
  logic [NUM_SUB-1:0] vl_last_q;
  logic [15:0] cfg_new;
  logic cfg_ok;
  logic nvl_ok;
  logic pw_match;
  logic accept;
  logic [SECT_W-1:0] arg_sect;
  logic [SECT_W-1:0] arg_sub;
  spp_snap_s live;
  spp_snap_s snap_q;
  logic snap_tog_q;

  // Maps a finished frame onto a command; wrong lengths decode to no command
  function automatic spp_cmd_e decode(input spp_frame_s f);
    spp_cmd_e c;
    c = SPP_CMD_NONE;
    if (f.op == OP_WR_SEAL && f.nbits == LEN_OP) begin
      c = SPP_CMD_WR_SEAL;
    end else if (f.op == OP_UNLOCK_PW && f.nbits == LEN_PW) begin
      c = SPP_CMD_UNLOCK;
    end else if (f.op == OP_PROG_PW && f.nbits == LEN_PW) begin
      c = SPP_CMD_PROG_PW;
    end else if (f.op == OP_WR_CFG && f.nbits == LEN_B2) begin
      c = SPP_CMD_WR_CFG;
    end else if (f.op == OP_WR_NVL && f.nbits == LEN_B1) begin
      c = SPP_CMD_WR_NVL;
    end else if (f.op == OP_ER_NVL && f.nbits == LEN_OP) begin
      c = SPP_CMD_ER_NVL;
    end else if (f.op == OP_WR_VL && f.nbits == LEN_B2) begin
      c = SPP_CMD_WR_VL;
    end
    return c;
  endfunction

  // Volatile lock state of one sector or subsector
  function automatic logic vl_of(input logic [SECT_W-1:0] s, input logic [SECT_W-1:0] u,
                                 input logic [NUM_SECT-1:0] mid,
                                 input logic [NUM_SUB-1:0] first,
                                 input logic [NUM_SUB-1:0] last);
    logic v;
    v = mid[s];
    if (s == SECT_W'(0)) begin
      v = first[u];
    end else if (s == SECT_W'(NUM_SECT - 1)) begin
      v = last[u];
    end
    return v;
  endfunction

  // Reset of the link side, carried into its own clock
  spp_sync u_rst_sync (
    .clk(link_clk),
    .rst(1'b0),
    .rst_val(1'b0),
    .d(srst),
    .q(link_rst)
  );

  // Select idles high, so its synchroniser resets high: no false frame end
  spp_sync u_cs_sync (
    .clk(core_clk),
    .rst(srst),
    .rst_val(1'b1),
    .d(link_cs_n),
    .q(cs_s)
  );

  // Acknowledge returned by the link side
  logic link_ack;

  spp_sync u_ack_sync (
    .clk(core_clk),
    .rst(srst),
    .rst_val(1'b0),
    .d(link_ack),
    .q(ack_s)
  );

  spp_link u_link (
    .link_clk(link_clk),
    .link_rst(link_rst),
    .link_cs_n(link_cs_n),
    .link_si(link_si),
    .link_so(link_so),
    .link_so_oe(link_so_oe),
    .frame(frame),
    .snap(snap_q),
    .snap_tog(snap_tog_q),
    .snap_ack(link_ack)
  );

  // Frame registers are still once the select has risen
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
    end
  end

  // Frame end is the first core cycle with the select seen high
  assign frame_end = cs_s && !cs_prev_q;
  assign cmd = frame_end ? decode(frame) : SPP_CMD_NONE;
  assign arg_sect = frame.data[11:8];
  assign arg_sub = frame.data[7:4];
  assign pw_enabled = !cfg_q[CFG_PW_BIT];
  assign seal_open = seal_q[0];
  assign pw_match = frame.data == pw_q;

  // Configuration bits only go 1 to 0, and never both to 0
  always_comb begin
    cfg_new = cfg_q;
    cfg_new[CFG_PW_BIT] = cfg_q[CFG_PW_BIT] & frame.data[CFG_PW_BIT];
    cfg_new[CFG_SP_BIT] = cfg_q[CFG_SP_BIT] & frame.data[CFG_SP_BIT];
    cfg_ok = cfg_new[CFG_PW_BIT] | cfg_new[CFG_SP_BIT];
  end

  assign nvl_ok = seal_q[0] && !pw_fail_q;

  // Acceptance of each decoded command
  always_comb begin
    accept = 1'b0;
    case (cmd)
      SPP_CMD_WR_SEAL: accept = 1'b1;
      SPP_CMD_UNLOCK: accept = !pw_enabled || pw_match;
      SPP_CMD_PROG_PW: accept = !pw_enabled;
      SPP_CMD_WR_CFG: accept = cfg_ok;
      SPP_CMD_WR_NVL: accept = nvl_ok;
      SPP_CMD_ER_NVL: accept = nvl_ok;
      SPP_CMD_WR_VL: accept = 1'b1;
      default: accept = 1'b0;
    endcase
  end

  // Answer pulses, one cycle each
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_done <= 1'b0;
      cmd_refused <= 1'b0;
    end else begin
      cmd_done <= (cmd != SPP_CMD_NONE) && accept;
      cmd_refused <= (cmd != SPP_CMD_NONE) && !accept;
    end
  end

  // Nonvolatile configuration, survives device resets
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cfg_q <= CFG_RESET;
    end else if (cmd == SPP_CMD_WR_CFG && accept) begin
      cfg_q <= cfg_new;
    end
  end

  // Nonvolatile password, frozen once password mode is on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pw_q <= PW_RESET;
    end else if (cmd == SPP_CMD_PROG_PW && accept) begin
      pw_q <= frame.data;
    end
  end

  // Persistent lock bits, all open from the factory
  always_ff @(posedge core_clk) begin
    if (srst) begin
      nvl_q <= NVL_RESET;
    end else if (cmd == SPP_CMD_ER_NVL && accept) begin
      nvl_q <= NVL_RESET;
    end else if (cmd == SPP_CMD_WR_NVL && accept) begin
      nvl_q[frame.data[3:0]] <= 1'b0;
    end
  end

  // Seal bit, closed at reset while password mode is on
  always_ff @(posedge core_clk) begin
    if (srst) begin
      seal_q <= SEAL_OPEN;
    end else if (dev_rst) begin
      seal_q <= pw_enabled ? SEAL_SHUT : SEAL_OPEN;
    end else if (cmd == SPP_CMD_UNLOCK && accept) begin
      seal_q <= SEAL_OPEN;
    end else if (cmd == SPP_CMD_WR_SEAL) begin
      seal_q <= SEAL_SHUT;
    end
  end

  // A wrong password keeps persistent locks frozen until reset or a correct password
  always_ff @(posedge core_clk) begin
    if (srst || dev_rst) begin
      pw_fail_q <= 1'b0;
    end else if (cmd == SPP_CMD_UNLOCK && !accept) begin
      pw_fail_q <= 1'b1;
    end else if (cmd == SPP_CMD_UNLOCK && accept) begin
      pw_fail_q <= 1'b0;
    end
  end

  // Volatile locks, per subsector in the end sectors
  always_ff @(posedge core_clk) begin
    if (srst || dev_rst) begin
      vl_q <= '0;
      vl_first_q <= '0;
      vl_last_q <= '0;
    end else if (cmd == SPP_CMD_WR_VL) begin
      if (arg_sect == SECT_W'(0)) begin
        vl_first_q[arg_sub] <= frame.data[0];
      end else if (arg_sect == SECT_W'(NUM_SECT - 1)) begin
        vl_last_q[arg_sub] <= frame.data[0];
      end else begin
        vl_q[arg_sect] <= frame.data[0];
      end
    end
  end

  // Program and erase gate for the array
  assign chk_allow = nvl_q[chk_sector] &&
                     !vl_of(chk_sector, chk_sub, vl_q, vl_first_q, vl_last_q);

  // Values offered to the link for read commands
  always_comb begin
    live.seal = seal_q;
    live.cfg = cfg_q;
    live.nvl = nvl_q;
    live.pw = pw_enabled ? 64'h0000_0000_0000_0000 : pw_q;
  end

  // Snapshot handshake: new data only after the link has acknowledged
  always_ff @(posedge core_clk) begin
    if (srst) begin
      snap_q <= '0;
      snap_tog_q <= 1'b0;
    end else if (ack_s == snap_tog_q && live != snap_q) begin
      snap_q <= live;
      snap_tog_q <= !snap_tog_q;
    end
  end
endmodule
`default_nettype wire

// File: spp_sva.sv
// Checker for the sector and password protection block
`timescale 1ns/1ps
`default_nettype none
module spp_sva (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic dev_rst,
  input wire logic seal_open,
  input wire logic pw_enabled,
  input wire logic cmd_done,
  input wire logic cmd_refused
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  reset_state_a: assert property (@(posedge core_clk) disable iff (1'b0)
    srst |=> seal_open && !pw_enabled && !cmd_done && !cmd_refused)
    else $error("state after reset wrong");
  pulse_excl_a: assert property (!(cmd_done && cmd_refused))
    else $error("done and refused together");
  pulse_once_a: assert property ((cmd_done || cmd_refused) |=> !cmd_done && !cmd_refused)
    else $error("answer pulse longer than one cycle");
  pw_seal_rst_a: assert property (dev_rst && pw_enabled |=> !seal_open)
    else $error("seal not closed by reset in password mode");
  open_seal_rst_a: assert property (dev_rst && !pw_enabled |=> seal_open)
    else $error("seal not opened by reset");
  seal_rise_a: assert property ($rose(seal_open) && !$past(dev_rst) |-> cmd_done)
    else $error("seal opened without accepted command");
  seal_fall_a: assert property ($fell(seal_open) && !$past(dev_rst) |-> cmd_done)
    else $error("seal closed without accepted command");
  refused_hold_a: assert property (cmd_refused |->
    seal_open == $past(seal_open) && pw_enabled == $past(pw_enabled))
    else $error("refused command changed state");
  pw_sticky_a: assert property (pw_enabled |=> pw_enabled)
    else $error("password mode left");
  pw_rise_a: assert property ($rose(pw_enabled) |-> cmd_done)
    else $error("password mode entered without command");
endmodule
`default_nettype wire

// File: spp_host.sv
// Host serial controller model issuing protection frames
`timescale 1ns/1ps
`default_nettype none
module spp_host (
  output var logic link_clk,
  output var logic link_cs_n,
  output var logic link_si,
  input wire logic link_so
);
  initial begin
    link_clk = 1'b0;
    link_cs_n = 1'b1;
    link_si = 1'b0;
  end
  // Free clock pulses with no frame, used only while the link side resets
  task automatic tick(input int n);
    repeat (n) begin
      #24 link_clk = 1'b1;
      #24 link_clk = 1'b0;
    end
  endtask
  // One frame: opcode, nb payload bits, then rb answer bits sampled on rises
  task automatic xfer(input logic [7:0] op, input logic [63:0] pl, input int nb,
                      input int rb, output logic [63:0] rd);
    logic [71:0] sh;
    sh = {op, pl << (64 - nb)};
    rd = 64'h0;
    link_cs_n = 1'b0;
    for (int i = 0; i < 8 + nb + rb; i++) begin
      // Not driving after the payload: toggle so no stale level is seen
      link_si = (i < 8 + nb) ? sh[71 - i] : ~link_si;
      #24 link_clk = 1'b1;
      if (i >= 8) rd = {rd[62:0], link_so};
      #24 link_clk = 1'b0;
    end
    link_si = ~link_si;
    #24 link_cs_n = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// File: spp_protect_test.sv
// Testbench for the sector and password protection block
`timescale 1ns/1ps
`default_nettype none
module spp_protect_test;
  import spp_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, dev_rst = 1'b0;
  logic link_clk, link_cs_n, link_si, link_so, link_so_oe;
  logic [SECT_W-1:0] chk_sector = 4'h0, chk_sub = 4'h0;
  logic chk_allow, pw_enabled, seal_open, cmd_done, cmd_refused;
  logic [63:0] v;
  logic [63:0] pw = 64'h0123_4567_89AB_CDEF;
  int n_fail = 0, n_tests = 0;
  always #2 core_clk = ~core_clk;
  spp_protect spp_protect_i (.core_clk(core_clk), .srst(srst), .dev_rst(dev_rst),
    .link_clk(link_clk), .link_cs_n(link_cs_n), .link_si(link_si), .link_so(link_so),
    .link_so_oe(link_so_oe), .chk_sector(chk_sector), .chk_sub(chk_sub),
    .chk_allow(chk_allow), .pw_enabled(pw_enabled), .seal_open(seal_open),
    .cmd_done(cmd_done), .cmd_refused(cmd_refused));
  spp_host spp_host_i (.link_clk(link_clk), .link_cs_n(link_cs_n), .link_si(link_si),
    .link_so(link_so));
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Frame with the pulse watch beside it: 1 = accepted, 2 = refused
  task automatic cmd(input logic [7:0] op, input logic [63:0] pl, input int nb,
                     input logic [1:0] exp);
    logic [63:0] d;
    logic [1:0] got;
    got = 2'h0;
    fork
      spp_host_i.xfer(op, pl, nb, 0, d);
      repeat ((8 + nb) * 12 + 30) begin
        @(negedge core_clk);
        if (got == 2'h0) got = {cmd_refused, cmd_done};
      end
    join
    check(got, exp);
  endtask
  // Read twice: the answer snapshot lags by about one frame
  task automatic rd(input logic [7:0] op, input int rb, output logic [63:0] r);
    spp_host_i.xfer(op, 64'h0, 0, rb, r);
    fork
      spp_host_i.xfer(op, 64'h0, 0, rb, r);
      #400 check(link_so_oe, 1'h1);
    join
    check(link_so_oe, 1'h0);
  endtask
  task automatic allow(input int s, input int sub, input logic exp);
    @(negedge core_clk);
    chk_sector = s[3:0];
    chk_sub = sub[3:0];
    #1 check(chk_allow, exp);
  endtask
  task automatic do_srst();
    @(negedge core_clk) srst = 1'b1;
    fork
      begin
        repeat (8) @(negedge core_clk);
        srst = 1'b0;
      end
      spp_host_i.tick(3);
    join
    repeat (4) @(negedge core_clk);
  endtask
  task automatic dev_reset();
    @(negedge core_clk) dev_rst = 1'b1;
    @(negedge core_clk) dev_rst = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_fresh();
    check(seal_open, 1'h1);
    check(pw_enabled, 1'h0);
    for (int s = 0; s < 16; s++) allow(s, s, 1'h1);
    rd(OP_RD_CFG, 16, v);
    check(v, CFG_RESET);
    rd(OP_RD_SEAL, 8, v);
    check(v, SEAL_OPEN);
    rd(OP_RD_NVL, 16, v);
    check(v, NVL_RESET);
    $display("t_fresh done");
  endtask
  task automatic t_locks();
    cmd(OP_WR_NVL, 64'h5, 8, 2'h1);
    allow(5, 0, 1'h0);
    allow(6, 0, 1'h1);
    rd(OP_RD_NVL, 16, v);
    check(v, 64'hFFDF);
    cmd(OP_WR_VL, 64'h0301, 16, 2'h1);
    allow(3, 0, 1'h0);
    cmd(OP_WR_VL, 64'h0021, 16, 2'h1);
    allow(0, 2, 1'h0);
    allow(0, 3, 1'h1);
    cmd(OP_WR_VL, 64'h0FF1, 16, 2'h1);
    allow(15, 15, 1'h0);
    allow(15, 14, 1'h1);
    dev_reset();
    allow(3, 0, 1'h1);
    allow(0, 2, 1'h1);
    allow(5, 0, 1'h0);
    cmd(OP_ER_NVL, 64'h0, 0, 2'h1);
    allow(5, 0, 1'h1);
    $display("t_locks done");
  endtask
  task automatic t_seal();
    cmd(OP_WR_NVL, 64'h7, 8, 2'h1);
    cmd(OP_WR_SEAL, 64'h0, 0, 2'h1);
    check(seal_open, 1'h0);
    rd(OP_RD_SEAL, 8, v);
    check(v, SEAL_SHUT);
    cmd(OP_WR_NVL, 64'h8, 8, 2'h2);
    cmd(OP_ER_NVL, 64'h0, 0, 2'h2);
    allow(7, 0, 1'h0);
    allow(8, 0, 1'h1);
    cmd(OP_UNLOCK_PW, 64'h0, 64, 2'h1);
    check(seal_open, 1'h1);
    cmd(OP_ER_NVL, 64'h0, 0, 2'h1);
    $display("t_seal done");
  endtask
  task automatic t_pw();
    cmd(OP_PROG_PW, pw, 64, 2'h1);
    rd(OP_RD_PW, 64, v);
    check(v, pw);
    cmd(OP_WR_CFG, 64'hFFFB, 16, 2'h1);
    check(pw_enabled, 1'h1);
    rd(OP_RD_CFG, 16, v);
    check(v, 64'hFFFB);
    cmd(OP_WR_CFG, 64'hFFFD, 16, 2'h2);
    cmd(OP_PROG_PW, ~pw, 64, 2'h2);
    rd(OP_RD_PW, 64, v);
    check(v, 64'h0);
    dev_reset();
    check(seal_open, 1'h0);
    cmd(OP_UNLOCK_PW, ~pw, 64, 2'h2);
    check(seal_open, 1'h0);
    cmd(OP_UNLOCK_PW, pw, 64, 2'h1);
    check(seal_open, 1'h1);
    cmd(OP_UNLOCK_PW, ~pw, 64, 2'h2);
    check(seal_open, 1'h1);
    cmd(OP_WR_NVL, 64'h2, 8, 2'h2);
    cmd(OP_UNLOCK_PW, pw, 64, 2'h1);
    cmd(OP_WR_NVL, 64'h2, 8, 2'h1);
    $display("t_pw done");
  endtask
  task automatic t_sp();
    do_srst();
    check(pw_enabled, 1'h0);
    cmd(OP_WR_CFG, 64'hFFFD, 16, 2'h1);
    cmd(OP_WR_CFG, 64'hFFFB, 16, 2'h2);
    check(pw_enabled, 1'h0);
    rd(OP_RD_CFG, 16, v);
    check(v, 64'hFFFD);
    dev_reset();
    check(seal_open, 1'h1);
    $display("t_sp done");
  endtask
  initial begin
    #300000;
    n_fail++;
    final_report();
  end
  initial begin
    do_srst();
    t_fresh();
    t_locks();
    t_seal();
    t_pw();
    t_sp();
    final_report();
  end
endmodule
bind spp_protect spp_sva spp_sva_i (.core_clk(core_clk), .srst(srst), .dev_rst(dev_rst),
  .seal_open(seal_open), .pw_enabled(pw_enabled), .cmd_done(cmd_done),
  .cmd_refused(cmd_refused));
`default_nettype wire
